// ==== lar_partner.sv ====
// Behavioural breaker for the auto-reclose bench.
// Assumes trip and close levels synchronous to aclk.
`timescale 1ns/100ps
module lar_partner (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic trip,
   input  wire logic close,
   output logic      breaker_open
);
   // The breaker stays open after a final trip, so idle with an open breaker gets exercised.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         breaker_open <= 1'b0;
      else if (trip)
         breaker_open <= 1'b1;
      else if (close)
         breaker_open <= 1'b0;
   end
endmodule // lar_partner

// ==== lar_pkg.sv ====
// Package for the line auto-reclose sequencer: register map, reset values,
// timing constants, state codes and the grouped input and output signals.
// Assumes one 10 MHz system clock and an AXI4-Lite register port.
package lar_pkg;
   localparam int LAR_CLK_PERIOD_NS = 100;
   localparam int LAR_TICK_NS       = 1000000;
   localparam int LAR_TICK_CYCLES   = (LAR_TICK_NS + LAR_CLK_PERIOD_NS - 1) / LAR_CLK_PERIOD_NS;
   localparam int LAR_TICKW         = 16;
   localparam int LAR_AW            = 8;
   localparam int LAR_NREG          = 16;
   localparam logic [3:0] LAR_IDX_CTRL    = 4'h0;
   localparam logic [3:0] LAR_IDX_ACTION  = 4'h1;
   localparam logic [3:0] LAR_IDX_CLOSE   = 4'h2;
   localparam logic [3:0] LAR_IDX_RECLAIM = 4'h3;
   localparam logic [3:0] LAR_IDX_DYNBLK  = 4'h4;
   localparam logic [3:0] LAR_IDX_REDUCED = 4'h5;
   localparam logic [3:0] LAR_IDX_SPECIAL = 4'h6;
   localparam logic [3:0] LAR_IDX_STATUS  = 4'h7;
   localparam int LAR_CTRL_SRC    = 0;
   localparam int LAR_CTRL_SYNSW  = 1;
   localparam int LAR_CTRL_SHOTS  = 2;
   localparam int LAR_CTRL_ACCEL  = 4;
   localparam int LAR_ST_CYCLE    = 4;
   localparam int LAR_ST_SUCCESS  = 8;
   localparam logic [31:0] LAR_CLOSE_MIN_MS = 32'h0000000a;
   localparam logic [31:0] LAR_CLOSE_MAX_MS = 32'h00002710;
   localparam logic [31:0] LAR_RST [LAR_NREG] = '{
      32'h00000005, 32'h000003e8, 32'h00000064, 32'h000007d0,
      32'h000005dc, 32'h0000012c, 32'h00000546, 32'h00000000,
      32'h000001f4, 32'h00000258, 32'h000002bc, 32'h00000320,
      32'h000003e8, 32'h000007d0, 32'h00000bb8, 32'h00000fa0};

   typedef enum logic [3:0] {
      LAR_IDLE       = 4'b0000,
      LAR_ACTION     = 4'b0001,
      LAR_WAIT_START = 4'b0010,
      LAR_DEAD       = 4'b0011,
      LAR_RECLAIM    = 4'b0100,
      LAR_FINAL      = 4'b0101,
      LAR_DYNBLK     = 4'b0110
   } lar_state_t;

   typedef struct packed {
      logic ar_external_block_in;
      logic ar_protection_start_in;
      logic ar_reclose_trip_in;
      logic ar_three_phase_trip_in;
      logic ar_special_first_dt_in;
      logic ar_breaker_open_in;
      logic ar_sync_release_in;
      logic ar_manual_close_in;
      logic ar_breaker_ready_in;
      logic ar_dead_time_hold_in;
      logic ar_reduce_dead_time_in;
   } lar_in_t;

   typedef struct packed {
      logic ar_blocked_out;
      logic ar_close_pulse_out;
      logic ar_sync_close_request_out;
      logic ar_final_trip_out;
      logic ar_trip_accel_out;
      logic ar_in_progress_out;
   } lar_out_t;
endpackage

// ==== lar_sequencer.sv ====
// Line auto-reclose sequencer with its settings store on AXI4-Lite.
// Assumes all inputs synchronous to aclk and a 10 MHz clock.
//
// Overview of operation
// - Pickup starts action timer; no trip before expiry enters dynamic block.
// - Start-source setting picks trip fall-away or breaker-open as cycle start.
// - The selected start condition starts the dead-time counter.
// - Four dead times each for three-phase and other trips, by cycle.
// - Dead-time expiry issues the close command without outside request.
// - Close is one common pulse of the close-pulse setting length.
// - Reclaim timer starts with the close command from its setting.
// - Reclaim period stretches until the close pulse has ended.
// - A new trip during reclaim advances to the next cycle.
// - Reclaim expiry without fault flags success and returns to idle.
// - A fault after reclaim expiry restarts at cycle one.
// - Pickup during reclaim keeps the sequence for a later trip.
// - After pickup, reclosing waits for the reclose-start trip.
// - No reclose while the synchro-check release is false.
// - Blocked output is true in the dynamic blocked state and while external block is held.
// - In-progress output is true while a sequence runs.
// - Dead-time hold input delays the dead-time start.
// - Reduce input applies the shortened dead time.
// - Special first dead time for three-phase faults when requested.
// - Synchronous switching raises a close request instead of a close.
// - External block input blocks the function while held.
// - Close pulse setting spans 10 to 10000 ms.
// - Final trip leads into the dynamic blocked state.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module lar_sequencer import lar_pkg::*; #(
   parameter int TICK_CYCLES = LAR_TICK_CYCLES
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire lar_in_t            ar_in,
   output lar_out_t                ar_out,
   input  wire logic [LAR_AW-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [LAR_AW-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready
);
   logic [31:0]          cfg_reg [LAR_NREG];
   lar_state_t           state_reg, state_next;
   logic [1:0]           cycle_reg, cycle_next;
   logic [31:0]          tmr_reg, tmr_next, pulse_reg, pulse_next;
   logic [LAR_TICKW-1:0] tick_cnt_reg;
   logic                 seq_reg, seq_next, pend_reg, pend_next;
   logic                 three_reg, three_next, succ_reg, succ_set;
   logic                 trip_prev_reg, start_prev_reg, load;
   lar_out_t             out_reg, out_next;
   logic                 awready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]           bresp_reg, rresp_reg;
   logic [31:0]          rdata_reg;

   // Bus decode.
   wire logic       wr_fire = awready_reg & s_axi_awvalid & s_axi_wvalid;
   wire logic       wr_ok   = (s_axi_awaddr[LAR_AW-1:6] == 2'h0);
   wire logic [3:0] widx    = s_axi_awaddr[5:2];
   wire logic       rd_fire = arready_reg & s_axi_arvalid;
   wire logic       rd_ok   = (s_axi_araddr[LAR_AW-1:6] == 2'h0);
   wire logic [3:0] ridx    = s_axi_araddr[5:2];
   wire logic [31:0] wmask  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire logic [31:0] status_word = {23'h0, succ_reg, 2'h0, cycle_reg, state_reg};
   wire logic       succ_clr = wr_fire & wr_ok & (widx == LAR_IDX_STATUS)
                               & s_axi_wstrb[1] & s_axi_wdata[LAR_ST_SUCCESS];

   // Settings decode.
   wire logic [31:0] ctrl      = cfg_reg[LAR_IDX_CTRL];
   wire logic        src_cb    = ctrl[LAR_CTRL_SRC];
   wire logic        synsw     = ctrl[LAR_CTRL_SYNSW];
   wire logic [1:0]  last_cyc  = ctrl[LAR_CTRL_SHOTS +: 2];
   wire logic        accel_en  = ctrl[LAR_CTRL_ACCEL];
   wire logic [31:0] close_set = cfg_reg[LAR_IDX_CLOSE];
   // Out-of-range pulse settings are clamped so a bad write cannot stall reclaim.
   wire logic [31:0] close_ms  = (close_set < LAR_CLOSE_MIN_MS) ? LAR_CLOSE_MIN_MS :
                                 (close_set > LAR_CLOSE_MAX_MS) ? LAR_CLOSE_MAX_MS :
                                 close_set;
   wire logic [3:0]  dt_idx    = {1'b1, three_reg, cycle_reg};
   wire logic [31:0] dead_ms   =
      ar_in.ar_reduce_dead_time_in ? cfg_reg[LAR_IDX_REDUCED] :
      (cycle_reg == 2'h0 && three_reg && ar_in.ar_special_first_dt_in) ?
         cfg_reg[LAR_IDX_SPECIAL] : cfg_reg[dt_idx];

   // Event and timer decode.
   wire logic trip_rise  = ar_in.ar_reclose_trip_in & ~trip_prev_reg;
   wire logic start_rise = ar_in.ar_protection_start_in & ~start_prev_reg;
   wire logic start_cond = src_cb ? ar_in.ar_breaker_open_in
                                  : ~ar_in.ar_reclose_trip_in;
   wire logic tick       = (tick_cnt_reg == LAR_TICKW'(TICK_CYCLES - 1));
   wire logic tmr_zero   = (tmr_reg == 32'h0);
   wire logic pulse_zero = (pulse_reg == 32'h0);
   wire logic last_shot  = (cycle_reg == last_cyc);
   wire logic close_ok   = ar_in.ar_sync_release_in & ar_in.ar_breaker_ready_in;

   genvar g;
   generate
      for (g = 0; g < LAR_NREG; g++) begin : g_cfg
         always_ff @(posedge aclk) begin
            if (!aresetn)
               cfg_reg[g] <= LAR_RST[g];
            else if (wr_fire && wr_ok && widx == 4'(g) && widx != LAR_IDX_STATUS)
               cfg_reg[g] <= (cfg_reg[g] & ~wmask) | (s_axi_wdata & wmask);
         end
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      cycle_next = cycle_reg;
      seq_next   = seq_reg;
      pend_next  = pend_reg;
      succ_set   = 1'b0;
      load       = 1'b0;
      tmr_next   = (tick && !tmr_zero) ? tmr_reg - 32'h1 : tmr_reg;
      pulse_next = (tick && !pulse_zero) ? pulse_reg - 32'h1 : pulse_reg;
      if (ar_in.ar_external_block_in) begin
         state_next = LAR_IDLE;
         cycle_next = 2'h0;
         seq_next   = 1'b0;
         pend_next  = 1'b0;
         pulse_next = 32'h0;
      end else if (ar_in.ar_manual_close_in) begin
         state_next = LAR_DYNBLK;
         cycle_next = 2'h0;
         seq_next   = 1'b0;
         pend_next  = 1'b0;
         pulse_next = 32'h0;
         tmr_next   = cfg_reg[LAR_IDX_DYNBLK];
         load       = 1'b1;
      end else begin
         case (state_reg)
            LAR_IDLE: begin
               if (trip_rise) begin
                  state_next = LAR_WAIT_START;
                  cycle_next = 2'h0;
                  seq_next   = 1'b1;
               end else if (start_rise) begin
                  state_next = LAR_ACTION;
                  tmr_next   = cfg_reg[LAR_IDX_ACTION];
                  load       = 1'b1;
               end
            end
            LAR_ACTION: begin
               if (trip_rise) begin
                  state_next = (seq_reg && last_shot) ? LAR_FINAL : LAR_WAIT_START;
                  cycle_next = seq_reg ? cycle_reg + 2'h1 : 2'h0;
                  seq_next   = 1'b1;
               end else if (tmr_zero) begin
                  state_next = LAR_DYNBLK;
                  seq_next   = 1'b0;
                  tmr_next   = cfg_reg[LAR_IDX_DYNBLK];
                  load       = 1'b1;
               end
            end
            LAR_WAIT_START: begin
               // A held start condition stays pending until the hold input drops.
               if (start_cond && !ar_in.ar_dead_time_hold_in) begin
                  state_next = LAR_DEAD;
                  tmr_next   = dead_ms;
                  load       = 1'b1;
               end
            end
            LAR_DEAD: begin
               if (trip_rise) begin
                  state_next = LAR_FINAL;
               end else if (tmr_zero && close_ok) begin
                  state_next = LAR_RECLAIM;
                  pend_next  = 1'b0;
                  pulse_next = close_ms;
                  tmr_next   = cfg_reg[LAR_IDX_RECLAIM];
                  load       = 1'b1;
               end
            end
            LAR_RECLAIM: begin
               if (start_rise)
                  pend_next = 1'b1;
               if (trip_rise) begin
                  state_next = last_shot ? LAR_FINAL : LAR_WAIT_START;
                  cycle_next = last_shot ? cycle_reg : cycle_reg + 2'h1;
                  pulse_next = 32'h0;
               end else if (tmr_zero && pulse_zero) begin
                  if (pend_reg || start_rise) begin
                     state_next = LAR_ACTION;
                     tmr_next   = cfg_reg[LAR_IDX_ACTION];
                     load       = 1'b1;
                  end else begin
                     state_next = LAR_IDLE;
                     cycle_next = 2'h0;
                     seq_next   = 1'b0;
                     succ_set   = 1'b1;
                  end
                  pend_next = 1'b0;
               end
            end
            LAR_FINAL: begin
               state_next = LAR_DYNBLK;
               seq_next   = 1'b0;
               cycle_next = 2'h0;
               tmr_next   = cfg_reg[LAR_IDX_DYNBLK];
               load       = 1'b1;
            end
            LAR_DYNBLK: begin
               if (tmr_zero)
                  state_next = LAR_IDLE;
            end
            default: begin
               state_next = LAR_IDLE;
               cycle_next = 2'h0;
               seq_next   = 1'b0;
            end
         endcase
      end
      three_next = (state_next == LAR_WAIT_START && state_reg != LAR_WAIT_START) ?
                   ar_in.ar_three_phase_trip_in : three_reg;
   end

   // Outputs are registered copies of the next state.
   always_comb begin
      out_next.ar_blocked_out = ar_in.ar_external_block_in
                                | (state_next == LAR_DYNBLK);
      out_next.ar_close_pulse_out = (state_next == LAR_RECLAIM) && (pulse_next != 32'h0)
                                    && !synsw;
      out_next.ar_sync_close_request_out = (state_next == LAR_RECLAIM)
                                           && (pulse_next != 32'h0) && synsw;
      out_next.ar_final_trip_out  = (state_next == LAR_FINAL);
      out_next.ar_trip_accel_out  = accel_en && (state_next == LAR_RECLAIM);
      out_next.ar_in_progress_out = seq_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= LAR_IDLE;
         cycle_reg      <= 2'h0;
         tmr_reg        <= 32'h0;
         pulse_reg      <= 32'h0;
         tick_cnt_reg   <= '0;
         seq_reg        <= 1'b0;
         pend_reg       <= 1'b0;
         three_reg      <= 1'b0;
         trip_prev_reg  <= 1'b0;
         start_prev_reg <= 1'b0;
         out_reg        <= '0;
      end else begin
         state_reg      <= state_next;
         cycle_reg      <= cycle_next;
         tmr_reg        <= tmr_next;
         pulse_reg      <= pulse_next;
         // Restarting the tick on every load makes each period a whole count of ms.
         tick_cnt_reg   <= (load || tick) ? '0 : tick_cnt_reg + 1'b1;
         seq_reg        <= seq_next;
         pend_reg       <= pend_next;
         three_reg      <= three_next;
         trip_prev_reg  <= ar_in.ar_reclose_trip_in;
         start_prev_reg <= ar_in.ar_protection_start_in;
         out_reg        <= out_next;
      end
   end

   // Success is sticky; a new success in the clearing cycle is kept.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         succ_reg <= 1'b0;
      else
         succ_reg <= succ_set | (succ_reg & ~succ_clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= 2'h0;
         rdata_reg   <= 32'h0;
      end else begin
         awready_reg <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready)
            bvalid_reg <= 1'b0;
         arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_ok ? 2'h0 : 2'h2;
            // The close setting reads back as the clamped value actually in force.
            rdata_reg  <= !rd_ok ? 32'h0 :
                          (ridx == LAR_IDX_STATUS) ? status_word :
                          (ridx == LAR_IDX_CLOSE) ? close_ms : cfg_reg[ridx];
         end else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   assign ar_out        = out_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = awready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire logic quiet = !ar_in.ar_external_block_in && !ar_in.ar_manual_close_in;

   sequence close_issue_s;
      (state_reg == LAR_RECLAIM) ##1
      (ar_out.ar_close_pulse_out || ar_out.ar_sync_close_request_out);
   endsequence

   action_expiry_a: assert property ((state_reg == LAR_ACTION) && tmr_zero && !trip_rise
      && quiet |=> state_reg == LAR_DYNBLK ##1 ar_out.ar_blocked_out)
      else $error("action time expiry did not block");
   dead_hold_a: assert property ((state_reg == LAR_WAIT_START) && ar_in.ar_dead_time_hold_in
      |=> state_reg != LAR_DEAD)
      else $error("dead time started under hold");
   dead_close_a: assert property ((state_reg == LAR_DEAD) && tmr_zero && close_ok
      && !trip_rise && quiet |=> close_issue_s)
      else $error("dead time expiry gave no close");
   async_close_a: assert property ((state_reg == LAR_DEAD) && !ar_in.ar_sync_release_in
      |=> state_reg != LAR_RECLAIM)
      else $error("close issued without synchro release");
   reclaim_stretch_a: assert property ((state_reg == LAR_RECLAIM) && !pulse_zero
      && !trip_rise && quiet |=> state_reg == LAR_RECLAIM)
      else $error("reclaim ended during close pulse");
   fault_advance_a: assert property ((state_reg == LAR_RECLAIM) && trip_rise && !last_shot
      && quiet |=> (state_reg == LAR_WAIT_START) && (cycle_reg == $past(cycle_reg) + 2'h1))
      else $error("fault in reclaim did not advance cycle");
   reclaim_success_a: assert property ((state_reg == LAR_RECLAIM) && tmr_zero && pulse_zero
      && !pend_reg && !start_rise && !trip_rise && quiet
      |=> (state_reg == LAR_IDLE) && (cycle_reg == 2'h0) && succ_reg)
      else $error("reclaim expiry not reported as success");
   ext_block_a: assert property (ar_in.ar_external_block_in
      |=> ar_out.ar_blocked_out && !ar_out.ar_in_progress_out)
      else $error("external block not honoured");
   final_dyn_a: assert property ($rose(ar_out.ar_final_trip_out) && quiet
      |=> ar_out.ar_blocked_out && !ar_out.ar_final_trip_out)
      else $error("final trip not followed by dynamic block");
   close_excl_a: assert property (!(ar_out.ar_close_pulse_out
      && ar_out.ar_sync_close_request_out))
      else $error("close and close request together");
   progress_a: assert property ((state_reg == LAR_DEAD) |-> ar_out.ar_in_progress_out)
      else $error("in-progress low during dead time");

endmodule // lar_sequencer

// ==== tb_line_auto_reclose_sequencer.sv ====
// Self-checking bench of the auto-reclose sequencer: settings over AXI4-Lite, reclose runs.
// Assumes lar_pkg, lar_partner and lar_sequencer are compiled first.
`timescale 1ns/100ps
module tb_line_auto_reclose_sequencer import lar_pkg::*;;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   lar_in_t     tin = '0;
   lar_in_t     ain;
   lar_out_t    o;
   logic [7:0]  awaddr = '0;
   logic [7:0]  araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, ip_end, bopen;
   logic [1:0]  bresp, rresp, rr;
   logic [31:0] rdata, v;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          n, w, rel_at;
   logic [39:0] cfg [10] = '{40'h0400000008, 40'h080000000a, 40'h0c00000019, 40'h100000000a,
      40'h1400000002, 40'h1800000009, 40'h2000000003, 40'h2400000005, 40'h3000000006,
      40'h3400000007};
   always_comb begin
      ain = tin;
      ain.ar_breaker_open_in = bopen;
   end
   initial forever #50 aclk = ~aclk;
   lar_sequencer #(.TICK_CYCLES(4)) uut (.aclk(aclk), .aresetn(aresetn), .ar_in(ain),
      .ar_out(o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   lar_partner bm (.aclk(aclk), .aresetn(aresetn), .trip(ain.ar_reclose_trip_in),
      .close(o.ar_close_pulse_out | o.ar_sync_close_request_out), .breaker_open(bopen));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic rng(input int got, input int lo, input int hi, input string m);
      cmp_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("MISMATCH %0t %s took %0d not %0d..%0d", $time, m, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
      rd(a);
      chk(v, e, m);
   endtask
   task automatic trip1;
      @(posedge aclk);
      tin.ar_reclose_trip_in <= 1'b1;
      @(posedge aclk);
      tin.ar_reclose_trip_in <= 1'b0;
   endtask
   // Waits for bit b of the outputs (0 run, 2 final trip, 5 blocked) to reach level lv.
   task automatic wfor(input int b, input logic lv, input int lo, input int hi);
      n = 0;
      while (o[b] !== lv && n < 90000) begin
         @(posedge aclk);
         n++;
      end
      rng(n, lo, hi, "output wait");
   endtask
   // One fault: trip held tl cycles, close expected base..base+8 cycles after the trip.
   task automatic shot(input int tl, input int base, input logic sy);
      n = 0;
      @(posedge aclk);
      tin.ar_reclose_trip_in <= 1'b1;
      tin.ar_protection_start_in <= 1'b0;
      while (!(o.ar_close_pulse_out | o.ar_sync_close_request_out) && n < 9000) begin
         @(posedge aclk);
         n++;
         if (n == tl) tin.ar_reclose_trip_in <= 1'b0;
         if (n == rel_at) begin
            tin.ar_sync_release_in <= 1'b1;
            tin.ar_dead_time_hold_in <= 1'b0;
         end
      end
      rng(n, base, base + 8, "dead time");
      chk(o.ar_sync_close_request_out, sy, "close kind");
      w = 0;
      while ((o.ar_close_pulse_out | o.ar_sync_close_request_out) && w < 90000) begin
         @(posedge aclk);
         w++;
         if (w == 30) ip_end = o.ar_in_progress_out;
      end
      rng(w, 40, 42, "close width");
      chk(ip_end, 1'b1, "run during close");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // About 1600 cycles are expected; twenty times that means a hang.
   initial begin
      #(32000 * 100);
      n_mismatch++;
      conclude();
   end
   initial begin
      tin.ar_sync_release_in = 1'b1;
      tin.ar_breaker_ready_in = 1'b1;
      rel_at = -1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rc(8'h00, LAR_RST[0], "ctrl reset");
      rc(8'h08, LAR_RST[2], "close reset");
      rc(8'h0c, LAR_RST[3], "reclaim reset");
      rc(8'h40, 32'h0, "hole data");
      chk(rr, 2'b10, "hole resp");
      wr(8'h08, 32'h4);
      rc(8'h08, LAR_CLOSE_MIN_MS, "close low clamp");
      wr(8'h08, 32'h3000);
      rc(8'h08, LAR_CLOSE_MAX_MS, "close high clamp");
      foreach (cfg[i]) wr(cfg[i][39:32], cfg[i][31:0]);
      $display("test registers done");
      tin.ar_protection_start_in <= 1'b1;
      shot(1, 12, 1'b0);
      wfor(0, 1'b0, 56, 64);
      rd(8'h1c);
      chk(v[8], 1'b1, "success flag");
      wr(8'h1c, 32'h100);
      rd(8'h1c);
      chk(v[8], 1'b0, "success clear");
      $display("test single shot done");
      tin.ar_three_phase_trip_in <= 1'b1;
      shot(1, 24, 1'b0);
      shot(1, 28, 1'b0);
      trip1();
      wfor(2, 1'b1, 0, 6);
      wfor(5, 1'b1, 0, 4);
      wfor(5, 1'b0, 36, 48);
      $display("test final trip done");
      tin.ar_three_phase_trip_in <= 1'b0;
      tin.ar_protection_start_in <= 1'b1;
      wfor(5, 1'b1, 32, 38);
      tin.ar_protection_start_in <= 1'b0;
      wfor(5, 1'b0, 36, 48);
      $display("test action timeout done");
      tin.ar_three_phase_trip_in <= 1'b1;
      tin.ar_special_first_dt_in <= 1'b1;
      shot(1, 36, 1'b0);
      wfor(0, 1'b0, 56, 64);
      tin.ar_three_phase_trip_in <= 1'b0;
      tin.ar_special_first_dt_in <= 1'b0;
      tin.ar_reduce_dead_time_in <= 1'b1;
      shot(1, 8, 1'b0);
      wfor(0, 1'b0, 56, 64);
      tin.ar_reduce_dead_time_in <= 1'b0;
      tin.ar_dead_time_hold_in <= 1'b1;
      rel_at = 20;
      shot(1, 32, 1'b0);
      wfor(0, 1'b0, 56, 64);
      tin.ar_sync_release_in <= 1'b0;
      rel_at = 40;
      shot(1, 40, 1'b0);
      wfor(0, 1'b0, 56, 64);
      $display("test dead time variants done");
      wr(8'h00, 32'h7);
      shot(1, 12, 1'b1);
      chk(o.ar_trip_accel_out, 1'b0, "accel off");
      wfor(0, 1'b0, 56, 64);
      wr(8'h00, 32'h14);
      shot(40, 52, 1'b0);
      chk(o.ar_trip_accel_out, 1'b1, "accel in reclaim");
      // Pickup inside reclaim, trip after it: the second dead time must follow.
      tin.ar_protection_start_in <= 1'b1;
      repeat (65) @(posedge aclk);
      shot(40, 60, 1'b0);
      wfor(0, 1'b0, 56, 64);
      wr(8'h0c, 32'h5);
      shot(40, 52, 1'b0);
      wfor(0, 1'b0, 0, 4);
      $display("test start source and reclaim done");
      tin.ar_external_block_in <= 1'b1;
      wfor(5, 1'b1, 0, 3);
      trip1();
      repeat (20) @(posedge aclk);
      chk(o.ar_in_progress_out, 1'b0, "run while blocked");
      chk(o.ar_blocked_out, 1'b1, "block held");
      tin.ar_external_block_in <= 1'b0;
      wfor(5, 1'b0, 0, 3);
      $display("test external block done");
      tin.ar_manual_close_in <= 1'b1;
      wfor(5, 1'b1, 0, 3);
      tin.ar_manual_close_in <= 1'b0;
      wfor(5, 1'b0, 36, 48);
      $display("test manual close done");
      conclude();
   end
endmodule // tb_line_auto_reclose_sequencer
